// file: core/sbsr_pkg.sv
// Shared constants and types for the serial boot swap reprogrammer
package sbsr_pkg;
	localparam int        CHAR_BITS     = 8;
	localparam int        ADDR_W        = 20;
	localparam int        OFS_W         = 10;
	localparam int        BLK_W         = ADDR_W - OFS_W;
	localparam int        PAYLOAD_BYTES = 256;
	localparam int        BLOCK_BYTES   = 1024;
	localparam logic[7:0] CODE_SOF      = 8'h01;
	localparam logic[7:0] CMD_START     = 8'h02;
	localparam logic[7:0] CMD_WRITE     = 8'h03;
	localparam logic[7:0] CMD_END       = 8'h04;
	localparam logic[15:0] LEN_SHORT    = 16'h0002;
	localparam logic[15:0] LEN_WRITE    = 16'h0102;
	localparam logic[7:0] WIN_FIRST     = 8'h00;
	localparam logic[7:0] WIN_LAST      = 8'h3f;
	localparam logic[ADDR_W-1:0] ADDR_START = 20'h01000;
	localparam logic[ADDR_W-1:0] ADDR_STEP  = 20'h00100;

	typedef enum logic [2:0] {
		FOP_GETWIN = 3'h0,
		FOP_SETWIN = 3'h1,
		FOP_BLANK  = 3'h2,
		FOP_ERASE  = 3'h3,
		FOP_WRITE  = 3'h4,
		FOP_VERIFY = 3'h5,
		FOP_INVERT = 3'h6
	} sbsr_fop_e;

	typedef enum logic [11:0] {
		ST_BOOT   = 12'h001,
		ST_RX     = 12'h002,
		ST_DECODE = 12'h004,
		ST_GETWIN = 12'h008,
		ST_SETWIN = 12'h010,
		ST_BLANK  = 12'h020,
		ST_ERASE  = 12'h040,
		ST_PROG   = 12'h080,
		ST_VERIFY = 12'h100,
		ST_INVERT = 12'h200,
		ST_RESET  = 12'h400,
		ST_ERROR  = 12'h800
	} sbsr_state_e;

	typedef enum logic [2:0] {
		FR_SOF  = 3'h0,
		FR_LENH = 3'h1,
		FR_LENL = 3'h2,
		FR_CMD  = 3'h3,
		FR_DATA = 3'h4,
		FR_SUM  = 3'h5
	} sbsr_frame_e;
endpackage

// file: core/sbsr_rx_if.sv
// Received character stream between the serial slave and the sequencer
`timescale 1ns/1ps
interface sbsr_rx_if;
	import sbsr_pkg::*;
	logic                 byteValid;
	logic [CHAR_BITS-1:0] byteData;
	modport source (output byteValid, output byteData);
	modport sink   (input byteValid, input byteData);
endinterface

// file: core/sbsr_serial_rx.sv
// Clocked 3-wire receive slave, MSB first, sampled on the rising link clock
`timescale 1ns/1ps
module sbsr_serial_rx
	import sbsr_pkg::*;
#(
	parameter int NBITS = CHAR_BITS
) (
	input  wire logic   sys_clk,
	input  wire logic   nrst,
	input  wire logic   serialClockIn,
	input  wire logic   serialDataIn,
	sbsr_rx_if.source   rx
);
	logic [2:0]       sclkSync_r;
	logic [1:0]       sdiSync_r;
	logic [NBITS-1:0] shift_r;
	logic [3:0]       bitCnt_r;
	logic             sclkRise;

	// Two flops before any use, third only for the edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			// Idle-high link clock, so no false edge after reset
			sclkSync_r <= 3'h7;
			sdiSync_r  <= 2'h0;
		end else begin
			sclkSync_r <= {sclkSync_r[1:0], serialClockIn};
			sdiSync_r  <= {sdiSync_r[0], serialDataIn};
		end
	end

	assign sclkRise = sclkSync_r[1] & ~sclkSync_r[2];

	// Single transfer, eight bits, MSB first, external clock
	always_ff @(posedge sys_clk or negedge nrst) begin // see (R1)
		if (!nrst) begin
			shift_r      <= '0;
			bitCnt_r     <= 4'h0;
			rx.byteValid <= 1'b0;
			rx.byteData  <= '0;
		end else begin
			rx.byteValid <= 1'b0;
			if (sclkRise) begin
				shift_r <= {shift_r[NBITS-2:0], sdiSync_r[1]};
				if (bitCnt_r == 4'(NBITS - 1)) begin
					bitCnt_r     <= 4'h0;
					rx.byteValid <= 1'b1;
					rx.byteData  <= {shift_r[NBITS-2:0], sdiSync_r[1]};
				end else begin
					bitCnt_r <= bitCnt_r + 4'h1;
				end
			end
		end
	end
endmodule

// file: core/sbsr_reprogrammer.sv
// Command sequencer that reprograms the alternate boot cluster
`timescale 1ns/1ps
// How it works
// (R1) Serial slave receives 8-bit MSB-first characters on the external clock.
// (R2) Idles in a low-power wait until a character completes.
// (R3) After reset raises the handshake, then waits for the first command.
// (R4) Sender opens the session with start command 0x02.
// (R5) On start: light indicator first, then drop the handshake.
// (R6) Reads protection window; rewrites it unless exactly blocks 0..63.
// (R7) Write pointer starts at 0x1000.
// (R8) Initialization success raises the handshake.
// (R9) Sender sends write command 0x03 with exactly 256 bytes.
// (R10) Handshake stays low during all programming work.
// (R11) Entering a new block: blank check, erase if not blank.
// (R12) Program payload at pointer, then advance pointer by 256.
// (R13) Every completed 1024-byte block is verified before the next.
// (R14) Success of a payload raises the handshake again.
// (R15) Sender follows with another write or end command 0x04.
// (R16) End: drop handshake, verify current block if partly written, invert boot flag.
// (R17) Then turn the indicator off and request internal reset.
// (R18) Any failure shows error and halts, handshake stays low.
// (R19) Frame: 0x01, two-byte length, command, data, checksum.
// (R20) Checksum is byte sum of command and data.
// (R21) Bad checksum or unknown command halts in the error state.
module sbsr_reprogrammer
	import sbsr_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              serialClockIn,
	input  wire logic              serialDataIn,
	output logic                   handshakePin,
	output logic                   flashAccessIndicator_n,
	output logic                   lowPowerWait,
	output logic                   errorShown,
	output logic                   resetRequest,
	output logic                   flReq,
	output sbsr_fop_e              flOp,
	output logic [ADDR_W-1:0]      flAddr,
	output logic [BLK_W-1:0]       flBlock,
	output logic [7:0]             flWinFirst,
	output logic [7:0]             flWinLast,
	output logic [7:0]             flWrData,
	input  wire logic              flDone,
	input  wire logic              flFail,
	input  wire logic              flBlank,
	input  wire logic [7:0]        flWinFirstIn,
	input  wire logic [7:0]        flWinLastIn,
	input  wire logic [7:0]        flWrIdx
);
	sbsr_rx_if rx ();

	sbsr_state_e     state_r;
	sbsr_frame_e     frame_r;
	logic [15:0]     len_r;
	logic [8:0]      dataLeft_r;
	logic [7:0]      dataIdx_r;
	logic [7:0]      cmd_r;
	logic [7:0]      sum_r;
	logic            frameOk_r;
	logic            started_r;
	logic            ending_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0]      payload [0:PAYLOAD_BYTES-1];
	logic [ADDR_W-1:0] addrNxt;

	sbsr_serial_rx #(.NBITS(CHAR_BITS)) u_rx (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.serialClockIn (serialClockIn),
		.serialDataIn  (serialDataIn),
		.rx            (rx.source)
	);

	assign addrNxt = addr_r + ADDR_STEP;

	// Frame parser, active only while reception is enabled
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			frame_r    <= FR_SOF;
			len_r      <= 16'h0000;
			dataLeft_r <= 9'h000;
			dataIdx_r  <= 8'h00;
			cmd_r      <= 8'h00;
			sum_r      <= 8'h00;
			frameOk_r  <= 1'b0;
		end else begin
			frameOk_r <= 1'b0;
			if (state_r == ST_RX && rx.byteValid) begin
				case (frame_r)
				FR_SOF: begin
					if (rx.byteData == CODE_SOF) begin // see (R19)
						frame_r <= FR_LENH;
					end
				end
				FR_LENH: begin
					len_r[15:8] <= rx.byteData;
					frame_r     <= FR_LENL;
				end
				FR_LENL: begin
					len_r[7:0] <= rx.byteData;
					frame_r    <= FR_CMD;
				end
				FR_CMD: begin
					cmd_r      <= rx.byteData;
					sum_r      <= rx.byteData; // see (R20)
					dataIdx_r  <= 8'h00;
					dataLeft_r <= len_r[8:0] - 9'h002;
					frame_r    <= (len_r == LEN_WRITE) ? FR_DATA : FR_SUM;
				end
				FR_DATA: begin
					payload[dataIdx_r] <= rx.byteData;
					sum_r      <= sum_r + rx.byteData; // see (R20)
					dataIdx_r  <= dataIdx_r + 8'h01;
					dataLeft_r <= dataLeft_r - 9'h001;
					if (dataLeft_r == 9'h001) begin
						frame_r <= FR_SUM;
					end
				end
				FR_SUM: begin
					frame_r   <= FR_SOF;
					frameOk_r <= 1'b1;
					sum_r     <= sum_r ^ rx.byteData;
				end
				default: begin
					frame_r <= FR_SOF;
				end
				endcase
			end
		end
	end

	// Payload byte offered to the flash writer
	always_ff @(posedge sys_clk) begin
		flWrData <= payload[flWrIdx];
	end

	// Main sequencer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r                <= ST_BOOT;
			handshakePin           <= 1'b0;
			flashAccessIndicator_n <= 1'b1;
			lowPowerWait           <= 1'b0;
			errorShown             <= 1'b0;
			resetRequest           <= 1'b0;
			flReq                  <= 1'b0;
			flOp                   <= FOP_GETWIN;
			flAddr                 <= '0;
			flBlock                <= '0;
			flWinFirst             <= 8'h00;
			flWinLast              <= 8'h00;
			started_r              <= 1'b0;
			ending_r               <= 1'b0;
			addr_r                 <= ADDR_START;
		end else begin
			case (state_r)
			ST_BOOT: begin
				handshakePin <= 1'b1; // see (R3)
				state_r      <= ST_RX;
			end
			ST_RX: begin
				lowPowerWait <= !rx.byteValid; // see (R2)
				if (frameOk_r) begin
					lowPowerWait <= 1'b0;
					handshakePin <= 1'b0; // see (R10)
					state_r      <= ST_DECODE;
					if (cmd_r == CMD_START) begin
						flashAccessIndicator_n <= 1'b0; // see (R5)
						handshakePin           <= 1'b1;
					end
				end
			end
			ST_DECODE: begin
				handshakePin <= 1'b0; // see (R5)
				if (sum_r != 8'h00) begin
					state_r <= ST_ERROR; // see (R21)
				end else if (cmd_r == CMD_START && len_r == LEN_SHORT) begin
					started_r <= 1'b1;
					addr_r    <= ADDR_START; // see (R7)
					flOp      <= FOP_GETWIN;
					flReq     <= 1'b1;
					state_r   <= ST_GETWIN;
				end else if (cmd_r == CMD_WRITE && len_r == LEN_WRITE
						&& started_r) begin
					flAddr  <= addr_r;
					flBlock <= addr_r[ADDR_W-1:OFS_W];
					flReq   <= 1'b1;
					if (addr_r[OFS_W-1:0] == '0) begin
						flOp    <= FOP_BLANK; // see (R11)
						state_r <= ST_BLANK;
					end else begin
						flOp    <= FOP_WRITE;
						state_r <= ST_PROG;
					end
				end else if (cmd_r == CMD_END && len_r == LEN_SHORT
						&& started_r) begin
					ending_r <= 1'b1;
					flBlock  <= addr_r[ADDR_W-1:OFS_W];
					flReq    <= 1'b1;
					if (addr_r[OFS_W-1:0] != '0) begin
						flOp    <= FOP_VERIFY; // see (R16)
						state_r <= ST_VERIFY;
					end else begin
						flOp    <= FOP_INVERT;
						state_r <= ST_INVERT;
					end
				end else begin
					state_r <= ST_ERROR; // see (R21)
				end
			end
			ST_GETWIN: begin
				if (flDone) begin
					flReq <= 1'b0;
					if (flFail) begin
						state_r <= ST_ERROR; // see (R18)
					end else if (flWinFirstIn != WIN_FIRST
							|| flWinLastIn != WIN_LAST) begin
						flOp       <= FOP_SETWIN; // see (R6)
						flWinFirst <= WIN_FIRST;
						flWinLast  <= WIN_LAST;
						flReq      <= 1'b1;
						state_r    <= ST_SETWIN;
					end else begin
						handshakePin <= 1'b1; // see (R8)
						state_r      <= ST_RX;
					end
				end
			end
			ST_SETWIN: begin
				if (flDone) begin
					flReq <= 1'b0;
					if (flFail) begin
						state_r <= ST_ERROR;
					end else begin
						handshakePin <= 1'b1; // see (R8)
						state_r      <= ST_RX;
					end
				end
			end
			ST_BLANK: begin
				if (flDone) begin
					if (flFail) begin
						flReq   <= 1'b0;
						state_r <= ST_ERROR;
					end else if (flBlank) begin
						flOp    <= FOP_WRITE;
						state_r <= ST_PROG;
					end else begin
						flOp    <= FOP_ERASE; // see (R11)
						state_r <= ST_ERASE;
					end
				end
			end
			ST_ERASE: begin
				if (flDone) begin
					if (flFail) begin
						flReq   <= 1'b0;
						state_r <= ST_ERROR;
					end else begin
						flOp    <= FOP_WRITE;
						state_r <= ST_PROG;
					end
				end
			end
			ST_PROG: begin
				if (flDone) begin
					flReq <= 1'b0;
					if (flFail) begin
						state_r <= ST_ERROR;
					end else begin
						addr_r <= addrNxt; // see (R12)
						if (addrNxt[OFS_W-1:0] == '0) begin
							flOp    <= FOP_VERIFY; // see (R13)
							flReq   <= 1'b1;
							state_r <= ST_VERIFY;
						end else begin
							handshakePin <= 1'b1; // see (R14)
							state_r      <= ST_RX;
						end
					end
				end
			end
			ST_VERIFY: begin
				if (flDone) begin
					flReq <= 1'b0;
					if (flFail) begin
						state_r <= ST_ERROR;
					end else if (ending_r) begin
						flOp    <= FOP_INVERT; // see (R16)
						flReq   <= 1'b1;
						state_r <= ST_INVERT;
					end else begin
						handshakePin <= 1'b1; // see (R14)
						state_r      <= ST_RX;
					end
				end
			end
			ST_INVERT: begin
				if (flDone) begin
					flReq <= 1'b0;
					if (flFail) begin
						state_r <= ST_ERROR;
					end else begin
						flashAccessIndicator_n <= 1'b1; // see (R17)
						state_r                <= ST_RESET;
					end
				end
			end
			ST_RESET: begin
				resetRequest <= 1'b1; // see (R17)
			end
			ST_ERROR: begin
				errorShown   <= 1'b1; // see (R18)
				handshakePin <= 1'b0;
				flReq        <= 1'b0;
			end
			default: begin
				state_r <= ST_ERROR;
			end
			endcase
		end
	end
endmodule

// file: sim/sbsr_reprogrammer_sva.sv
// Port assertions for the reprogrammer
`timescale 1ns/1ps
module sbsr_reprogrammer_sva
	import sbsr_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              nrst,
	input wire logic              handshakePin,
	input wire logic              flashAccessIndicator_n,
	input wire logic              lowPowerWait,
	input wire logic              errorShown,
	input wire logic              resetRequest,
	input wire logic              flReq,
	input wire sbsr_fop_e         flOp,
	input wire logic [ADDR_W-1:0] flAddr,
	input wire logic [7:0]        flWinFirst,
	input wire logic [7:0]        flWinLast,
	input wire logic              flDone,
	input wire logic              flBlank
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_ready_after_reset;
		$rose(nrst) |-> ##[1:3] handshakePin;
	endproperty
	a_ready_after_reset: assert property (p_ready_after_reset)
		else $error("handshake not raised after reset");
	property p_light_then_busy;
		$fell(flashAccessIndicator_n) |-> handshakePin ##1 !handshakePin;
	endproperty
	a_light_then_busy: assert property (p_light_then_busy)
		else $error("indicator and handshake out of order");
	property p_window;
		flReq && flOp == FOP_SETWIN |-> flWinFirst == 8'h00 && flWinLast == 8'h3f;
	endproperty
	a_window: assert property (p_window)
		else $error("wrong protection window");
	property p_busy_in_work;
		flReq |-> !handshakePin;
	endproperty
	a_busy_in_work: assert property (p_busy_in_work)
		else $error("handshake high during flash work");
	property p_erase_after_blank;
		flReq && flOp == FOP_ERASE && $past(flOp) != FOP_ERASE
			|-> $past(flOp) == FOP_BLANK && $past(flDone) && !$past(flBlank);
	endproperty
	a_erase_after_blank: assert property (p_erase_after_blank)
		else $error("erase without failed blank check");
	property p_write_addr;
		flReq && flOp == FOP_WRITE |-> flAddr[7:0] == 8'h00 && flAddr >= 20'h01000;
	endproperty
	a_write_addr: assert property (p_write_addr)
		else $error("write address off its grid");
	property p_halt;
		errorShown |=> errorShown && !handshakePin && !flReq;
	endproperty
	a_halt: assert property (p_halt)
		else $error("activity after error");
	property p_reset_req;
		$rose(resetRequest) |-> flashAccessIndicator_n && $past(flashAccessIndicator_n);
	endproperty
	a_reset_req: assert property (p_reset_req)
		else $error("reset requested with indicator lit");
	property p_wait;
		lowPowerWait |-> handshakePin && !flReq;
	endproperty
	a_wait: assert property (p_wait)
		else $error("low power wait outside reception");
endmodule
bind sbsr_reprogrammer sbsr_reprogrammer_sva u_sbsr_reprogrammer_sva (
	.sys_clk(sys_clk), .nrst(nrst), .handshakePin(handshakePin),
	.flashAccessIndicator_n(flashAccessIndicator_n),
	.lowPowerWait(lowPowerWait), .errorShown(errorShown),
	.resetRequest(resetRequest), .flReq(flReq), .flOp(flOp),
	.flAddr(flAddr), .flWinFirst(flWinFirst), .flWinLast(flWinLast),
	.flDone(flDone), .flBlank(flBlank));

// file: sim/sbsr_serial_master.sv
// Serial master model sending command frames
`timescale 1ns/1ps
module sbsr_serial_master (
	output logic      serialClock,
	output logic      serialData,
	input  wire logic busyPin
);
	initial begin
		serialClock = 1'b1;
		serialData  = 1'b0;
	end
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			serialClock = 1'b0;
			serialData  = b[i];
			#40 serialClock = 1'b1;
			#40;
		end
		serialData = ~serialData;
	endtask
	task automatic send_frame(input logic [7:0] cmd, input int n,
		input logic [7:0] base, input logic [7:0] sumErr);
		logic [7:0] sum;
		sum = cmd;
		wait (busyPin === 1'b1);
		send_byte(8'h01);
		send_byte({7'h00, n != 0});
		send_byte(8'h02);
		send_byte(cmd);
		for (int i = 0; i < n; i++) begin
			send_byte(8'(i) + base);
			sum += 8'(i) + base;
		end
		send_byte(sum ^ sumErr);
	endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the reprogrammer
`timescale 1ns/1ps
module tb_top;
	import sbsr_pkg::*;
	logic              sys_clk, nrst, sClk, sData, flDone, flFail, flBlank;
	logic              hsPin, indN, lowPw, errSh, rstReq, flReq;
	sbsr_fop_e         flOp;
	logic [ADDR_W-1:0] flAddr;
	logic [BLK_W-1:0]  flBlock;
	logic [7:0]        winF, winL, winFIn, winLIn, wrData, wrIdx, fillBase;
	logic [19:0]       arg;
	logic [22:0]       logQ[$];
	int                fails, n_checks, cycles, waitCnt;

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	sbsr_reprogrammer u_sbsr_reprogrammer (
		.sys_clk(sys_clk), .nrst(nrst), .serialClockIn(sClk),
		.serialDataIn(sData), .handshakePin(hsPin),
		.flashAccessIndicator_n(indN), .lowPowerWait(lowPw),
		.errorShown(errSh), .resetRequest(rstReq), .flReq(flReq),
		.flOp(flOp), .flAddr(flAddr), .flBlock(flBlock),
		.flWinFirst(winF), .flWinLast(winL), .flWrData(wrData),
		.flDone(flDone), .flFail(flFail), .flBlank(flBlank),
		.flWinFirstIn(winFIn), .flWinLastIn(winLIn), .flWrIdx(wrIdx));
	sbsr_serial_master u_sbsr_serial_master (
		.serialClock(sClk), .serialData(sData), .busyPin(hsPin));

	task automatic check(input logic [22:0] seen, input logic [22:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Flash engine: answers each request after three cycles
	always @(posedge sys_clk) begin
		#1 flDone = 1'b0;
		waitCnt = flReq === 1'b1 ? waitCnt + 1 : 0;
		if (waitCnt == 3) begin
			flDone  = 1'b1;
			waitCnt = 0;
			arg = {10'h000, flBlock};
			if (flOp == FOP_WRITE) arg = flAddr;
			if (flOp == FOP_SETWIN) arg = {4'h0, winF, winL};
			if (flOp == FOP_GETWIN || flOp == FOP_INVERT) arg = 20'h0;
			logQ.push_back({flOp, arg});
			if (flOp == FOP_WRITE) check(wrData, 8'h5a + fillBase);
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 95000) begin
			fails++;
			complete_run;
		end
	end

	task automatic do_reset;
		#1 nrst = 1'b0;
		logQ.delete();
		repeat (20) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic wait_flag(ref logic f, input logic v);
		for (int i = 0; i < 3000 && f !== v; i++) @(posedge sys_clk);
		check(f, v);
	endtask
	task automatic wait_ops(input int n);
		for (int i = 0; i < 3000 && logQ.size() < n; i++)
			@(posedge sys_clk);
		check(logQ.size(), n);
	endtask
	task automatic expect_op(input sbsr_fop_e op, input logic [19:0] a);
		check(logQ.size() > 0 ? logQ.pop_front() : 23'h0, {op, a});
	endtask
	task automatic test_reset_state;
		check(hsPin, 1'b1);
		check({indN, errSh, rstReq}, 3'b100);
		check(lowPw, 1'b1);
	endtask
	task automatic test_start;
		u_sbsr_serial_master.send_frame(CMD_START, 0, 8'h00, 8'h00);
		wait_ops(2);
		wait_flag(hsPin, 1'b1);
		expect_op(FOP_GETWIN, 20'h0);
		expect_op(FOP_SETWIN, 20'h0003f);
		check(indN, 1'b0);
	endtask
	task automatic test_writes;
		fillBase = 8'h00;
		u_sbsr_serial_master.send_frame(CMD_WRITE, 256, fillBase, 8'h00);
		wait_ops(3);
		wait_flag(hsPin, 1'b1);
		expect_op(FOP_BLANK, 20'h00004);
		expect_op(FOP_ERASE, 20'h00004);
		expect_op(FOP_WRITE, 20'h01000);
		fillBase = 8'h33;
		u_sbsr_serial_master.send_frame(CMD_WRITE, 256, fillBase, 8'h00);
		wait_ops(1);
		wait_flag(hsPin, 1'b1);
		expect_op(FOP_WRITE, 20'h01100);
	endtask
	task automatic test_end;
		u_sbsr_serial_master.send_frame(CMD_END, 0, 8'h00, 8'h00);
		wait_ops(2);
		expect_op(FOP_VERIFY, 20'h00004);
		expect_op(FOP_INVERT, 20'h0);
		wait_flag(rstReq, 1'b1);
		check({indN, hsPin}, 2'b10);
	endtask
	task automatic test_errors;
		for (int k = 0; k < 2; k++) begin
			do_reset;
			u_sbsr_serial_master.send_frame(k ? CMD_START : CMD_END, 0,
				8'h00, k ? 8'h01 : 8'h00);
			wait_flag(errSh, 1'b1);
			check({hsPin, logQ.size() == 0}, 2'b01);
		end
	endtask
	// Window already correct: no rewrite, reception enabled again
	task automatic test_window_kept;
		do_reset;
		winFIn = WIN_FIRST;
		u_sbsr_serial_master.send_frame(CMD_START, 0, 8'h00, 8'h00);
		wait_ops(1);
		wait_flag(hsPin, 1'b1);
		expect_op(FOP_GETWIN, 20'h0);
		check(logQ.size(), 0);
		check({indN, errSh}, 2'b00);
	endtask

	initial begin
		{nrst, flDone, flFail, flBlank} = 4'h0;
		{wrIdx, winFIn, winLIn, fillBase} = {8'h5a, 8'h02, 8'h3f, 8'h00};
		{fails, n_checks, cycles, waitCnt} = {32'd0, 32'd0, 32'd0, 32'd0};
		do_reset;
		test_reset_state;
		test_start;
		test_writes;
		test_end;
		test_errors;
		test_window_kept;
		complete_run;
	end
endmodule
